// ---- pkg/ascif_map.svh ----
// Constants of the converter serial link and of the controller register map.
`ifndef ASCIF_MAP_SVH
`define ASCIF_MAP_SVH
`define ASCIF_CTRL_OFS 4'h0
`define ASCIF_STATUS_OFS 4'h4
`define ASCIF_RESULT_OFS 4'h8
`define ASCIF_CLKDIV_OFS 4'hC
`define ASCIF_CTRL_GO_BIT 8
`define ASCIF_STAT_BUSY_BIT 0
`define ASCIF_STAT_DONE_BIT 1
`define ASCIF_RES_DATA_LSB 16
`define ASCIF_CB_START 7
`define ASCIF_CB_SEL_HI 6
`define ASCIF_CB_SEL_LO 4
`define ASCIF_CB_POL 3
`define ASCIF_CB_CFG 2
`define ASCIF_CB_MODE_HI 1
`define ASCIF_CB_MODE_LO 0
`define ASCIF_TRACK_BITS 5
`define ASCIF_CTRL_BITS 8
`define ASCIF_RES_BITS 10
`define ASCIF_FRAME_BITS 24
`define ASCIF_RAW_RES_LSB 5
`define ASCIF_CLK_PERIOD_NS 100
`define ASCIF_INT_CONV_NS 7500
`define ASCIF_INT_CONV_CYC (`ASCIF_INT_CONV_NS / `ASCIF_CLK_PERIOD_NS)
`define ASCIF_EXT_CONV_MAX_NS 120000
`define ASCIF_SCLK_MIN_PERIOD_NS 500
`define ASCIF_HALF_MAX (`ASCIF_EXT_CONV_MAX_NS / (`ASCIF_FRAME_BITS * 2 * `ASCIF_CLK_PERIOD_NS))
`define ASCIF_HALF_MIN_RATE ((`ASCIF_SCLK_MIN_PERIOD_NS + 2 * `ASCIF_CLK_PERIOD_NS - 1) / (2 * `ASCIF_CLK_PERIOD_NS))
`define ASCIF_HALF_MIN_LAT 4
`define ASCIF_CLKDIV_RST 5
`define ASCIF_CFG_RST 8'h13
`endif

// ---- pkg/ascif_pkg.sv ----
// Types for the two ends of the converter serial link, with one state record for each end.
package ascif_pkg;
  typedef enum logic [1:0] {
    MODE_FULL_PD = 2'b00,
    MODE_FAST_PD = 2'b01,
    MODE_INT_CLK = 2'b10,
    MODE_EXT_CLK = 2'b11
  } ascif_mode_t;
  typedef enum logic [1:0] {
    P_IDLE = 2'b00,
    P_STROBE = 2'b01,
    P_EXT = 2'b11,
    P_INT = 2'b10
  } ascif_phase_t;
  typedef enum logic [2:0] {
    H_IDLE = 3'b000,
    H_SETUP = 3'b001,
    H_HI = 3'b011,
    H_LO = 3'b010,
    H_END = 3'b110
  } ascif_hstate_t;
  typedef struct packed {
    logic sclk_a;
    logic sclk_b;
    logic sclk_c;
    logic cs_a;
    logic cs_b;
    logic cs_c;
    logic din_a;
    logic din_b;
    logic rx_active;
    logic [3:0] rx_cnt;
    logic [7:0] rx_sr;
    logic restart;
    ascif_phase_t phase;
    logic [9:0] result;
    logic [9:0] out_sr;
    logic [3:0] out_cnt;
    logic int_rdy;
    logic [6:0] int_cnt;
    logic ext;
    logic [1:0] mode;
    logic track;
    logic hold;
    logic dout;
    logic dout_oe_n;
    logic strobe;
    logic strobe_oe_n;
    logic busy;
  } ascif_dev_t;
  typedef struct packed {
    logic awready;
    logic wready;
    logic aw_got;
    logic w_got;
    logic [3:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [7:0] cfg;
    logic [7:0] clkdiv;
    logic done;
    logic [15:0] raw;
    ascif_hstate_t st;
    logic [7:0] div_cnt;
    logic [4:0] bit_idx;
    logic [23:0] tx_sr;
    logic [23:0] rx_sr;
    logic dout_a;
    logic dout_b;
    logic cs_n;
    logic sclk;
    logic din;
  } ascif_host_t;
endpackage

// ---- pkg/ascif_link_if.sv ----
// Five-wire link between the converter and its serial master.
`timescale 1ns/1ps
`default_nettype none
interface ascif_link_if;
  logic cs_n;
  logic sclk;
  logic din;
  logic dout;
  logic dout_oe_n;
  logic strobe;
  logic strobe_oe_n;
  logic dout_line;
  logic strobe_line;
  // A released line reads low, as with a weak pull-down.
  assign dout_line = ~dout_oe_n & dout;
  assign strobe_line = ~strobe_oe_n & strobe;
  modport dev (input cs_n, input sclk, input din, output dout, output dout_oe_n, output strobe, output strobe_oe_n);
  modport host (output cs_n, output sclk, output din, input dout_line);
endinterface
`default_nettype wire

// ---- hw/ascif_device.sv ----
// Converter end: serial control byte decode, track/hold sequencing and result readout.
//
// The address map and the AXI4-Lite register port were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "ascif_map.svh"
module ascif_device
  import ascif_pkg::*;
#(
  parameter int INT_CONV_CYC = `ASCIF_INT_CONV_CYC
)
(
  input wire logic clk,
  input wire logic srst,
  ascif_link_if.dev link,
  input wire logic [3:0][9:0] ain,
  input wire logic [9:0] com,
  output logic th_track,
  output logic th_hold,
  output logic conv_busy,
  output logic [1:0] mode_field
);
  ascif_dev_t r;
  ascif_dev_t n;
  logic rise;
  logic fall;
  logic cs_low;
  logic cs_fall;
  logic cs_rise;
  logic accept;
  logic [9:0] sample;

  function automatic logic [9:0] conv_code(input logic [3:0][9:0] a, input logic [9:0] c, input logic [7:0] cb);
    logic [1:0] p;
    logic [1:0] m;
    logic ok;
    logic [9:0] mv;
    logic signed [10:0] d;
    logic signed [10:0] h;
    p = 2'h0;
    m = 2'h0;
    ok = 1'b1;
    case (cb[`ASCIF_CB_SEL_HI:`ASCIF_CB_SEL_LO])
      3'h1:
      begin
        p = 2'h0;
        m = 2'h1;
      end
      3'h5:
      begin
        p = 2'h1;
        m = 2'h0;
      end
      3'h2:
      begin
        p = 2'h2;
        m = 2'h3;
      end
      3'h6:
      begin
        p = 2'h3;
        m = 2'h2;
      end
      default:
        ok = 1'b0;
    endcase
    mv = cb[`ASCIF_CB_CFG] ? c : a[m];
    d = signed'({1'b0, a[p]}) - signed'({1'b0, mv});
    h = d >>> 1;
    if (!ok)
      conv_code = 10'h000;
    else if (cb[`ASCIF_CB_POL])
      conv_code = d[10] ? 10'h000 : d[9:0];
    else
      conv_code = h[9:0];
  endfunction

  assign rise = r.sclk_b & ~r.sclk_c;
  assign fall = ~r.sclk_b & r.sclk_c;
  assign cs_low = ~r.cs_b;
  assign cs_fall = ~r.cs_b & r.cs_c;
  assign cs_rise = r.cs_b & ~r.cs_c;
  assign accept = ~r.rx_active & (r.restart | (r.phase == P_IDLE) | ((r.phase == P_EXT) & (r.out_cnt <= 4'h3)));
  assign sample = conv_code(ain, com, r.rx_sr);

  always_comb
  begin
    n = r;
    n.sclk_a = link.sclk;
    n.sclk_b = r.sclk_a;
    n.sclk_c = r.sclk_b;
    n.cs_a = link.cs_n;
    n.cs_b = r.cs_a;
    n.cs_c = r.cs_b;
    n.din_a = link.din;
    n.din_b = r.din_a;
    if (r.phase == P_INT)
    begin
      if (r.int_cnt <= 7'h01)
      begin
        n.phase = P_IDLE;
        n.strobe = 1'b1;
        n.int_rdy = 1'b1;
        n.hold = 1'b0;
      end
      else
        n.int_cnt = r.int_cnt - 7'h01;
    end
    if (cs_rise)
    begin
      n.rx_active = 1'b0;
      n.restart = 1'b1;
      n.dout_oe_n = 1'b1;
      if (r.ext)
        n.strobe_oe_n = 1'b1;
    end
    if (cs_fall)
    begin
      n.dout_oe_n = 1'b0;
      n.dout = 1'b0;
      if (r.ext)
      begin
        n.strobe_oe_n = 1'b0;
        n.strobe = 1'b0;
      end
    end
    if (cs_low & rise)
    begin
      if (r.rx_active)
      begin
        n.rx_sr = {r.rx_sr[6:0], r.din_b};
        n.rx_cnt = r.rx_cnt + 4'h1;
      end
      else if (accept & r.din_b)
      begin
        n.rx_active = 1'b1;
        n.restart = 1'b0;
        n.rx_sr = 8'h01;
        n.rx_cnt = 4'h1;
      end
    end
    if (cs_low & fall)
    begin
      if (r.rx_active & (r.rx_cnt == 4'(`ASCIF_TRACK_BITS)))
        n.track = 1'b1;
      if (r.rx_active & (r.rx_cnt == 4'(`ASCIF_CTRL_BITS)))
      begin
        n.track = 1'b0;
        n.hold = 1'b1;
        n.rx_active = 1'b0;
        n.result = sample;
        n.mode = r.rx_sr[`ASCIF_CB_MODE_HI:`ASCIF_CB_MODE_LO];
        n.out_cnt = 4'h0;
        n.int_rdy = 1'b0;
        n.dout = 1'b0;
        case (ascif_mode_t'(r.rx_sr[`ASCIF_CB_MODE_HI:`ASCIF_CB_MODE_LO]))
          MODE_EXT_CLK:
          begin
            n.phase = P_STROBE;
            n.ext = 1'b1;
            n.strobe = 1'b1;
            n.strobe_oe_n = 1'b0;
          end
          MODE_INT_CLK:
          begin
            n.phase = P_INT;
            n.ext = 1'b0;
            n.strobe = 1'b0;
            n.strobe_oe_n = 1'b0;
            n.int_cnt = 7'(INT_CONV_CYC);
          end
          default:
          begin
            n.phase = P_IDLE;
            n.ext = 1'b0;
            n.hold = 1'b0;
            n.strobe = 1'b1;
            n.strobe_oe_n = 1'b0;
          end
        endcase
      end
      else if (r.phase == P_STROBE)
      begin
        n.strobe = 1'b0;
        n.phase = P_EXT;
        n.dout = r.result[9];
        n.out_sr = {r.result[8:0], 1'b0};
        n.out_cnt = 4'(`ASCIF_RES_BITS - 1);
      end
      else if (r.int_rdy)
      begin
        n.int_rdy = 1'b0;
        n.dout = r.result[9];
        n.out_sr = {r.result[8:0], 1'b0};
        n.out_cnt = 4'(`ASCIF_RES_BITS - 1);
      end
      else if (r.out_cnt != 4'h0)
      begin
        n.dout = r.out_sr[9];
        n.out_sr = {r.out_sr[8:0], 1'b0};
        n.out_cnt = r.out_cnt - 4'h1;
        if ((r.out_cnt == 4'h1) & (r.phase == P_EXT))
        begin
          n.phase = P_IDLE;
          n.hold = 1'b0;
        end
      end
      else
        n.dout = 1'b0;
    end
    // Busy is kept in a register so the output does not depend on a compare after the flop.
    n.busy = n.phase != P_IDLE;
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      r <= '0;
      r.sclk_a <= 1'b0;
      r.cs_a <= 1'b1;
      r.cs_b <= 1'b1;
      r.cs_c <= 1'b1;
      r.phase <= P_IDLE;
      r.mode <= MODE_INT_CLK;
      r.dout_oe_n <= 1'b1;
      r.strobe <= 1'b1;
      r.strobe_oe_n <= 1'b0;
    end
    else
      r <= n;
  end

  assign link.dout = r.dout;
  assign link.dout_oe_n = r.dout_oe_n;
  assign link.strobe = r.strobe;
  assign link.strobe_oe_n = r.strobe_oe_n;
  assign th_track = r.track;
  assign th_hold = r.hold;
  assign conv_busy = r.busy;
  assign mode_field = r.mode;
endmodule
`default_nettype wire

// ---- hw/ascif_host.sv ----
// Serial master end: AXI4-Lite register front and the three-byte external-clock exchange.
`timescale 1ns/1ps
`default_nettype none
`include "ascif_map.svh"
module ascif_host
  import ascif_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  ascif_link_if.host link,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [3:0] s_axi_araddr,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp
);
  ascif_host_t r;
  ascif_host_t n;
  logic busy;

  function automatic logic mapped(input logic [3:0] a);
    mapped = (a == `ASCIF_CTRL_OFS) | (a == `ASCIF_STATUS_OFS) | (a == `ASCIF_RESULT_OFS) | (a == `ASCIF_CLKDIV_OFS);
  endfunction

  assign busy = r.st != H_IDLE;

  always_comb
  begin
    n = r;
    n.dout_a = link.dout_line;
    n.dout_b = r.dout_a;
    if (s_axi_awvalid & r.awready)
    begin
      n.aw_got = 1'b1;
      n.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid & r.wready)
    begin
      n.w_got = 1'b1;
      n.wdata = s_axi_wdata;
      n.wstrb = s_axi_wstrb;
    end
    if (r.bvalid & s_axi_bready)
      n.bvalid = 1'b0;
    if (n.aw_got & n.w_got & ~n.bvalid)
    begin
      n.aw_got = 1'b0;
      n.w_got = 1'b0;
      n.bvalid = 1'b1;
      n.bresp = mapped(n.awaddr) ? 2'h0 : 2'h2;
      if ((n.awaddr == `ASCIF_CTRL_OFS) & n.wstrb[0])
        n.cfg = n.wdata[7:0];
      if ((n.awaddr == `ASCIF_STATUS_OFS) & n.wstrb[0] & n.wdata[`ASCIF_STAT_DONE_BIT])
        n.done = 1'b0;
      if ((n.awaddr == `ASCIF_CLKDIV_OFS) & n.wstrb[0])
      begin
        if (n.wdata[7:0] < 8'(`ASCIF_HALF_MIN_LAT))
          n.clkdiv = 8'(`ASCIF_HALF_MIN_LAT);
        else if (n.wdata[7:0] > 8'(`ASCIF_HALF_MAX))
          n.clkdiv = 8'(`ASCIF_HALF_MAX);
        else
          n.clkdiv = n.wdata[7:0];
      end
      if ((n.awaddr == `ASCIF_CTRL_OFS) & n.wstrb[1] & n.wdata[`ASCIF_CTRL_GO_BIT] & ~busy)
      begin
        n.st = H_SETUP;
        n.cs_n = 1'b0;
        n.sclk = 1'b0;
        n.div_cnt = r.clkdiv;
        n.bit_idx = 5'h00;
        n.tx_sr = {1'b1, n.cfg[6:2], 2'b11, 16'h0000};
        n.din = 1'b1;
      end
    end
    n.awready = ~n.aw_got & ~n.bvalid;
    n.wready = ~n.w_got & ~n.bvalid;
    if (r.rvalid & s_axi_rready)
      n.rvalid = 1'b0;
    if (s_axi_arvalid & r.arready)
    begin
      n.rvalid = 1'b1;
      n.rresp = mapped(s_axi_araddr) ? 2'h0 : 2'h2;
      n.rdata = 32'h00000000;
      case (s_axi_araddr)
        `ASCIF_CTRL_OFS:
          n.rdata = {24'h000000, r.cfg};
        `ASCIF_STATUS_OFS:
          n.rdata = {30'h00000000, r.done, busy};
        `ASCIF_RESULT_OFS:
          n.rdata = {6'h00, r.raw[`ASCIF_RAW_RES_LSB + 9:`ASCIF_RAW_RES_LSB], r.raw};
        `ASCIF_CLKDIV_OFS:
          n.rdata = {24'h000000, r.clkdiv};
        default:
          n.rdata = 32'h00000000;
      endcase
    end
    n.arready = ~n.rvalid;
    if (busy)
    begin
      if (r.div_cnt > 8'h01)
        n.div_cnt = r.div_cnt - 8'h01;
      else
      begin
        n.div_cnt = r.clkdiv;
        case (r.st)
          H_SETUP, H_LO:
          begin
            n.sclk = 1'b1;
            n.st = H_HI;
          end
          H_HI:
          begin
            // capture ahead of the falling edge
            n.rx_sr = {r.rx_sr[22:0], r.dout_b};
            n.sclk = 1'b0;
            n.bit_idx = r.bit_idx + 5'h01;
            if (r.bit_idx == 5'(`ASCIF_FRAME_BITS - 1))
              n.st = H_END;
            else
            begin
              n.tx_sr = {r.tx_sr[22:0], 1'b0};
              n.din = r.tx_sr[22];
              n.st = H_LO;
            end
          end
          H_END:
          begin
            // deselect, keep the two readout bytes
            n.cs_n = 1'b1;
            n.st = H_IDLE;
            n.done = 1'b1;
            n.raw = r.rx_sr[15:0];
            n.din = 1'b0;
          end
          default:
            n.st = H_IDLE;
        endcase
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      r <= '0;
      r.awready <= 1'b1;
      r.wready <= 1'b1;
      r.arready <= 1'b1;
      r.cfg <= `ASCIF_CFG_RST;
      r.clkdiv <= 8'(`ASCIF_CLKDIV_RST);
      r.st <= H_IDLE;
      r.cs_n <= 1'b1;
    end
    else
      r <= n;
  end

  assign link.cs_n = r.cs_n;
  assign link.sclk = r.sclk;
  assign link.din = r.din;
  assign s_axi_awready = r.awready;
  assign s_axi_wready = r.wready;
  assign s_axi_bvalid = r.bvalid;
  assign s_axi_bresp = r.bresp;
  assign s_axi_arready = r.arready;
  assign s_axi_rvalid = r.rvalid;
  assign s_axi_rdata = r.rdata;
  assign s_axi_rresp = r.rresp;
endmodule
`default_nettype wire

// ---- tb/ascif_link_asserts.sv ----
// Concurrent checks on the converter serial link and the converter's track/hold outputs.
`timescale 1ns/1ps
`default_nettype none
module ascif_link_asserts
  import ascif_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic din,
  input wire logic dout,
  input wire logic dout_oe_n,
  input wire logic strobe,
  input wire logic strobe_oe_n,
  input wire logic th_track,
  input wire logic th_hold,
  input wire logic [1:0] mode_field
);
  default clocking dcb @(posedge clk);
  endclocking
  default disable iff (srst);
  // The figures assume the reset divider of five clocks, so one serial period is ten clocks.
  sequence s_pulse_one_period;
    strobe[*8] ##1 strobe[*2] ##1 !strobe;
  endsequence
  sequence s_track_to_hold;
    !th_hold ##30 (th_hold && !th_track);
  endsequence
  dout_release_a: assert property (cs_n[*6] |-> dout_oe_n)
    else $error("dout driven while deselected");
  ext_strobe_release_a: assert property ((cs_n && mode_field == MODE_EXT_CLK)[*6] |-> strobe_oe_n)
    else $error("strobe driven while deselected in external mode");
  ext_strobe_low_a: assert property ($fell(cs_n) && mode_field == MODE_EXT_CLK |-> ##[2:6] (!strobe && !strobe_oe_n))
    else $error("strobe not driven low after select");
  int_strobe_driven_a: assert property (mode_field == MODE_INT_CLK |-> !strobe_oe_n)
    else $error("strobe released in internal mode");
  strobe_pulse_width_a: assert property ($rose(strobe) && !strobe_oe_n && mode_field == MODE_EXT_CLK |-> s_pulse_one_period)
    else $error("strobe pulse not one serial period");
  track_hold_gap_a: assert property ($rose(th_track) |-> s_track_to_hold)
    else $error("hold not three serial periods after track");
  hold_zero_lead_a: assert property ($rose(th_hold) |-> !dout ##10 !strobe)
    else $error("no leading zero or strobe not ended");
  no_track_idle_a: assert property (cs_n[*6] |-> !th_track)
    else $error("tracking while deselected");
  sclk_idle_low_a: assert property (cs_n |-> !sclk)
    else $error("serial clock high while deselected");
  din_stable_rise_a: assert property ($rose(sclk) |-> $stable(din))
    else $error("data changed at rising serial clock");
  start_bit_first_a: assert property ($fell(cs_n) |-> din)
    else $error("frame does not open with start bit");
endmodule
`default_nettype wire

// ---- tb/test_adc_serial_control_interface.sv ----
// Bench: AXI4-Lite driven conversions through the host end against the converter end.
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp, msg) begin checks_done++; if ((got) !== (exp)) begin mismatches++; $display("MISMATCH t=%0t %s", $time, msg); end end
module test_adc_serial_control_interface
  import ascif_pkg::*;
;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic [3:0][9:0] ain = '0;
  logic [9:0] com = '0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [3:0] awaddr = 4'h0, araddr = 4'h0;
  logic [31:0] wdata = 32'h0;
  logic awready, wready, bvalid, arready, rvalid, th_track, th_hold, conv_busy, sclk_prev = 1'b0;
  logic [1:0] bresp, rresp, mode_field;
  logic [31:0] rdata;
  int mismatches = 0;
  int checks_done = 0;
  int cycles = 0;
  int sclk_rises = 0;
  localparam logic [7:0] CB_TAB [10] = '{8'h9F, 8'hDF, 8'hAF, 8'hEF, 8'h93, 8'hA3, 8'hD3, 8'hE3, 8'h9B, 8'h8F};
  ascif_link_if link ();
  ascif_host ascif_host_inst (.clk(clk), .srst(srst), .link(link), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_awaddr(awaddr), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_bresp(bresp),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_araddr(araddr), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .s_axi_rdata(rdata), .s_axi_rresp(rresp));
  ascif_device #(.INT_CONV_CYC(5)) ascif_device_inst (.clk(clk), .srst(srst), .link(link), .ain(ain), .com(com),
    .th_track(th_track), .th_hold(th_hold), .conv_busy(conv_busy), .mode_field(mode_field));
  ascif_link_asserts ascif_link_asserts_inst (.clk(clk), .srst(srst), .cs_n(link.cs_n), .sclk(link.sclk),
    .din(link.din), .dout(link.dout), .dout_oe_n(link.dout_oe_n), .strobe(link.strobe),
    .strobe_oe_n(link.strobe_oe_n), .th_track(th_track), .th_hold(th_hold), .mode_field(mode_field));
  initial
  begin
    forever #50 clk = ~clk;
  end
  task automatic report_and_stop;
    $display("Mismatches %0d, checks %0d", mismatches, checks_done);
    if (mismatches == 0 && checks_done > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 40000)
    begin
      mismatches++;
      report_and_stop();
    end
  end
  // Counts serial clock rises in each frame; the count is checked when select goes back high.
  always @(posedge clk)
  begin
    sclk_prev <= link.sclk;
    if (!srst && link.cs_n === 1'b0 && link.sclk && !sclk_prev)
      sclk_rises <= sclk_rises + 1;
    if (!srst && link.cs_n === 1'b1 && sclk_rises != 0)
    begin
      `CHK(sclk_rises, 24, "serial clocks per frame")
      sclk_rises <= 0;
    end
  end
  task automatic axi_write(input logic [3:0] addr, input logic [31:0] data, output logic [1:0] resp);
    @(posedge clk);
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    awaddr <= addr;
    wdata <= data;
    bready <= 1'b1;
    forever
    begin
      @(posedge clk);
      if (awvalid && awready)
        awvalid <= 1'b0;
      if (wvalid && wready)
        wvalid <= 1'b0;
      if (bvalid)
      begin
        resp = bresp;
        bready <= 1'b0;
        break;
      end
    end
  endtask
  task automatic axi_read(input logic [3:0] addr, output logic [31:0] data, output logic [1:0] resp);
    @(posedge clk);
    arvalid <= 1'b1;
    araddr <= addr;
    rready <= 1'b1;
    forever
    begin
      @(posedge clk);
      if (arvalid && arready)
        arvalid <= 1'b0;
      if (rvalid)
      begin
        data = rdata;
        resp = rresp;
        rready <= 1'b0;
        break;
      end
    end
  endtask
  // Expected code from channel codes, input configuration and polarity; unknown codes give zero.
  function automatic logic [9:0] exp_res(input logic [7:0] b);
    logic [10:0] p;
    logic [10:0] m;
    logic [10:0] d;
    m = {1'b0, com};
    case (b[6:4])
      3'h1: p = {1'b0, ain[0]};
      3'h5: p = {1'b0, ain[1]};
      3'h2: p = {1'b0, ain[2]};
      3'h6: p = {1'b0, ain[3]};
      default: return 10'h000;
    endcase
    if (!b[2])
      case (b[6:4])
        3'h1: m = {1'b0, ain[1]};
        3'h5: m = {1'b0, ain[0]};
        3'h2: m = {1'b0, ain[3]};
        default: m = {1'b0, ain[2]};
      endcase
    d = p - m;
    if (b[3])
      return d[10] ? 10'h000 : d[9:0];
    return d[10:1];
  endfunction
  initial
  begin
    logic [31:0] rd;
    logic [1:0] rs;
    logic [7:0] cb;
    int n;
    ain[0] <= 10'h050;
    ain[1] <= 10'h200;
    ain[2] <= 10'h3F0;
    ain[3] <= 10'h0A0;
    com <= 10'h020;
    repeat (4) @(posedge clk);
    srst <= 1'b0;
    repeat (4) @(posedge clk);
    `CHK(mode_field, MODE_INT_CLK, "reset mode")
    `CHK(link.strobe_line, 1'b1, "strobe idle level")
    `CHK(link.dout_oe_n, 1'b1, "data output released")
    axi_read(4'h0, rd, rs);
    `CHK(rd[7:0], 8'h13, "control image reset")
    axi_read(4'hC, rd, rs);
    `CHK(rd[7:0], 8'h05, "divider reset")
    axi_read(4'h2, rd, rs);
    `CHK(rs, 2'h2, "unmapped read response")
    `CHK(rd, 32'h0, "unmapped read data")
    for (int k = 0; k < 10; k++)
    begin
      cb = CB_TAB[k];
      axi_write(4'h4, 32'h2, rs);
      axi_write(4'h0, {24'h000001, cb}, rs);
      `CHK(rs, 2'h0, "start accepted")
      rd = 32'h0;
      for (n = 0; n < 200 && !rd[1]; n++)
        axi_read(4'h4, rd, rs);
      `CHK(rd[1:0], 2'h2, "frame complete")
      `CHK(mode_field, MODE_EXT_CLK, "external mode decoded")
      `CHK(conv_busy, 1'b0, "conversion finished")
      axi_read(4'h8, rd, rs);
      `CHK(rd[25:16], exp_res(cb), "conversion result")
      `CHK(rd[15], 1'b0, "leading zero")
      `CHK(rd[4:0], 5'h00, "trailing zeros")
    end
    axi_write(4'hC, 32'h000000C8, rs);
    axi_read(4'hC, rd, rs);
    `CHK(rd[7:0], 8'h19, "divider upper clamp")
    axi_write(4'hC, 32'h00000001, rs);
    axi_read(4'hC, rd, rs);
    `CHK(rd[7:0], 8'h04, "divider lower clamp")
    axi_write(4'h2, 32'h00000001, rs);
    `CHK(rs, 2'h2, "unmapped write response")
    axi_read(4'h0, rd, rs);
    `CHK(rd[7:0], CB_TAB[9], "unmapped write ignored")
    report_and_stop();
  end
endmodule
`default_nettype wire
